// ---- hdl/aim_pkg.sv ----
/*
  Constants, field positions and carrier structs for the acquisition
  interrupt and scan control register bank.
  Assumes a 16-bit word-wide host register port and synchronous inputs.
*/
package aim_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [1:0] AIM_OFF_IRQ = 2'h0;
  localparam logic [1:0] AIM_OFF_SCAN = 2'h2;

  // ----------------------------------------------------------------
  // Interrupt register fields
  // ----------------------------------------------------------------
  localparam int AIM_B_SRC_LO = 0;
  localparam int AIM_B_GEN_EN = 2;
  localparam int AIM_B_DHF_EN = 3;
  localparam int AIM_B_ACQ_EN = 4;
  localparam int AIM_B_DHF = 5;
  localparam int AIM_B_ACQ = 6;
  localparam int AIM_B_GEN = 7;
  localparam int AIM_B_EXT = 8;
  localparam int AIM_B_BURST = 9;
  localparam int AIM_B_AHF = 10;
  localparam int AIM_B_ANE = 11;
  localparam int AIM_B_ANE_LIVE = 12;
  localparam int AIM_B_DEM_EN = 12;
  localparam int AIM_B_OVF = 13;
  localparam int AIM_B_DEM = 14;

  // ----------------------------------------------------------------
  // Scan register fields and reset values
  // ----------------------------------------------------------------
  localparam int AIM_B_START = 0;
  localparam int AIM_B_STOP = 4;
  localparam int AIM_B_RANGE = 8;
  localparam int AIM_B_SE = 10;
  localparam int AIM_B_POL = 11;
  localparam int AIM_B_PACER = 12;
  localparam logic [15:0] AIM_IRQ_WR_MASK = 16'h101f;
  localparam logic [15:0] AIM_SCAN_WR_MASK = 16'h3fff;
  localparam logic [15:0] AIM_RST_WORD = 16'h0000;
  localparam logic [8:0] AIM_HALF_LEVEL = 9'h0ff;

  typedef enum logic [1:0] {
    AIM_SRC_EXT = 2'b00,
    AIM_SRC_SCAN = 2'b01,
    AIM_SRC_HALF = 2'b10,
    AIM_SRC_NE = 2'b11
  } aim_src_e;

  typedef enum logic [1:0] {
    AIM_PACE_SW = 2'b00,
    AIM_PACE_CTR = 2'b01,
    AIM_PACE_FALL = 2'b10,
    AIM_PACE_RISE = 2'b11
  } aim_pace_e;

  // Events coming in from the converter, FIFOs and pins
  typedef struct packed {
    logic ext_irq;
    logic conv_done;
    logic burst_end;
    logic burst_on;
    logic acq_done;
    logic dac_half_full;
    logic dac_empty;
    logic adc_overrun;
    logic adc_fifo_clear;
    logic [8:0] adc_level;
  } aim_evt_s;

  // Analog front-end settings going out
  typedef struct packed {
    logic [3:0] channel;
    logic [1:0] range_select;
    logic single_vs_diff_sel;
    logic polarity_sel;
    logic [1:0] pacer_source_sel;
  } aim_fe_s;

endpackage : aim_pkg

// ---- hdl/aim_regs.sv ----
/*
  Interrupt/FIFO status and channel scan control registers.
  Assumes host strobes are one-cycle, synchronous, word wide.
*/
module aim_regs
  import aim_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [1:0] host_addr,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  input wire aim_evt_s evt,
  output aim_fe_s fe,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic wr_irq;
  logic wr_scan;
  logic ext_d_reg;
  logic ext_rise;
  logic adc_ne;
  logic adc_half;
  logic gen_evt;
  logic [15:0] ctl_reg;
  logic [15:0] scan_reg;
  logic [3:0] chan_reg;
  logic dhf_reg;
  logic acq_reg;
  logic gen_reg;
  logic ext_reg;
  logic bur_reg;
  logic ahf_reg;
  logic ane_reg;
  logic ovf_reg;
  logic dem_reg;
  logic [15:0] rd_next;

  assign wr_irq = host_wr && (host_addr == AIM_OFF_IRQ);
  assign wr_scan = host_wr && (host_addr == AIM_OFF_SCAN);
  assign ext_rise = evt.ext_irq && !ext_d_reg;
  assign adc_ne = (evt.adc_level != 9'h000);
  assign adc_half = (evt.adc_level > AIM_HALF_LEVEL);

  // ----------------------------------------------------------------
  // General source select
  // ----------------------------------------------------------------
  always_comb
  begin
    case (aim_src_e'(ctl_reg[AIM_B_SRC_LO +: 2]))
      AIM_SRC_EXT: gen_evt = ext_rise;
      AIM_SRC_SCAN: gen_evt = evt.conv_done && (chan_reg == fe_stop());
      AIM_SRC_HALF: gen_evt = adc_half;
      AIM_SRC_NE: gen_evt = adc_ne;
      default: gen_evt = 1'b0;
    endcase
  end

  function automatic logic [3:0] fe_stop();
    fe_stop = scan_reg[AIM_B_STOP +: 4];
  endfunction

  // ----------------------------------------------------------------
  // Control storage
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      ctl_reg <= AIM_RST_WORD;
    else if (wr_irq)
      ctl_reg <= host_wdata & AIM_IRQ_WR_MASK;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      scan_reg <= AIM_RST_WORD;
    else if (wr_scan)
      scan_reg <= host_wdata & AIM_SCAN_WR_MASK;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      ext_d_reg <= 1'b0;
    else
      ext_d_reg <= evt.ext_irq;
  end

  // ----------------------------------------------------------------
  // Scan channel sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      chan_reg <= 4'h0;
    else if (wr_scan)
      chan_reg <= host_wdata[AIM_B_START +: 4];
    else if (evt.conv_done)
    begin
      if (chan_reg == fe_stop())
        chan_reg <= scan_reg[AIM_B_START +: 4];
      else
        chan_reg <= chan_reg + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Status flags; an event set wins over the host clear
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      dhf_reg <= 1'b0;
    else if (evt.dac_half_full && ctl_reg[AIM_B_DHF_EN])
      dhf_reg <= 1'b1;
    else if (wr_irq && host_wdata[AIM_B_DHF])
      dhf_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      acq_reg <= 1'b0;
    else if (evt.acq_done && ctl_reg[AIM_B_ACQ_EN])
      acq_reg <= 1'b1;
    else if (wr_irq && host_wdata[AIM_B_ACQ])
      acq_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      gen_reg <= 1'b0;
    else if (gen_evt && ctl_reg[AIM_B_GEN_EN])
      gen_reg <= 1'b1;
    else if (wr_irq && host_wdata[AIM_B_GEN])
      gen_reg <= 1'b0;
  end

  // External flag clears with the general clear, whatever the source select
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      ext_reg <= 1'b0;
    else if (ext_rise)
      ext_reg <= 1'b1;
    else if (wr_irq && host_wdata[AIM_B_GEN])
      ext_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      bur_reg <= 1'b0;
    else if (!evt.burst_on)
      bur_reg <= 1'b0;
    else if (evt.burst_end)
      bur_reg <= 1'b1;
    else if (wr_irq && host_wdata[AIM_B_GEN])
      bur_reg <= 1'b0;
  end

  // Level driven; follows the FIFO so it drops once drained below half
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      ahf_reg <= 1'b0;
    else if (adc_half)
      ahf_reg <= 1'b1;
    else if (evt.adc_fifo_clear || !adc_half)
      ahf_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      ane_reg <= 1'b0;
    else if (evt.adc_fifo_clear || !adc_ne)
      ane_reg <= 1'b0;
    else
      ane_reg <= 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      ovf_reg <= 1'b0;
    else if (evt.adc_overrun)
      ovf_reg <= 1'b1;
    else if (wr_irq && host_wdata[AIM_B_OVF])
      ovf_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      dem_reg <= 1'b0;
    else if (evt.dac_empty && ctl_reg[AIM_B_DEM_EN])
      dem_reg <= 1'b1;
    else if (wr_irq && host_wdata[AIM_B_DEM])
      dem_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_next = 16'h0000;
    if (host_addr == AIM_OFF_IRQ)
    begin
      rd_next[AIM_B_DHF] = dhf_reg;
      rd_next[AIM_B_ACQ] = acq_reg;
      rd_next[AIM_B_GEN] = gen_reg;
      rd_next[AIM_B_EXT] = ext_reg;
      rd_next[AIM_B_BURST] = bur_reg;
      rd_next[AIM_B_AHF] = ahf_reg;
      rd_next[AIM_B_ANE] = ane_reg;
      rd_next[AIM_B_ANE_LIVE] = adc_ne;
      rd_next[AIM_B_OVF] = ovf_reg;
      rd_next[AIM_B_DEM] = dem_reg;
    end
    else if (host_addr == AIM_OFF_SCAN)
      rd_next = scan_reg;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      host_rdata <= 16'h0000;
    else if (host_rd)
      host_rdata <= rd_next;
  end

  // ----------------------------------------------------------------
  // Front-end outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      fe <= '0;
    else
    begin
      fe.channel <= chan_reg;
      fe.range_select <= scan_reg[AIM_B_RANGE +: 2];
      fe.single_vs_diff_sel <= scan_reg[AIM_B_SE];
      fe.polarity_sel <= scan_reg[AIM_B_POL];
      fe.pacer_source_sel <= scan_reg[AIM_B_PACER +: 2];
    end
  end

  // Shared request line, OR of the latched enabled flags
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      irq_out <= 1'b0;
    else
      irq_out <= dhf_reg | acq_reg | gen_reg | dem_reg;
  end

endmodule // aim_regs

// ---- testbench/aim_regs_props.sv ----
/*
  Port checker for the interrupt and scan control register bank.
  Assumes one clock domain and is bound to every aim_regs instance.
*/
module aim_regs_props
  import aim_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [1:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata,
  input wire aim_evt_s evt,
  input wire aim_fe_s fe,
  input wire logic irq_out
);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Read taken, then a quiet cycle so the answer cannot move
  sequence s_rd(ok);
    host_rd && ok ##1 !host_rd;
  endsequence
  sequence s_scan_wr;
    host_wr && host_addr == 2'h2 ##1 (!host_wr)[*3];
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_rdata_hold: assert property (!host_rd && !$past(host_rd) |=>
    $stable(host_rdata)) else $error("read data moved");
  a_odd_zero: assert property (s_rd(host_addr[0]) |=>
    host_rdata == 16'h0000) else $error("unmapped read not zero");
  a_irq_spare: assert property (s_rd(host_addr == 2'h0) |=>
    host_rdata[4:0] == 5'h00 && !host_rdata[15]) else $error("spare set");
  a_scan_spare: assert property (s_rd(host_addr == 2'h2) |=>
    host_rdata[15:14] == 2'h0) else $error("scan spare set");
  // Live bit is taken from the level seen on the read edge
  a_live_ne: assert property (s_rd(host_addr == 2'h0) |=>
    host_rdata[12] == ($past(evt.adc_level, 2) != 9'h000))
    else $error("live level wrong");
  a_burst_gate: assert property (!evt.burst_on ##1
    s_rd(!evt.burst_on && host_addr == 2'h0) |=> !host_rdata[9])
    else $error("burst flag without burst mode");
  // Low six bits of fe are range, front end, polarity and pacer
  a_set_hold: assert property ((!host_wr)[*3] |=>
    $stable(fe[5:0])) else $error("settings moved without write");
  a_chan_hold: assert property ((!host_wr && !evt.conv_done)[*3]
    |=> $stable(fe.channel)) else $error("channel moved idle");
  // Struct order differs from the register word, so compare field by field
  a_scan_wr: assert property (s_scan_wr |=>
    {fe.pacer_source_sel, fe.polarity_sel, fe.single_vs_diff_sel,
    fe.range_select} == $past(host_wdata[13:8], 4))
    else $error("settings lost");
endmodule // aim_regs_props

bind aim_regs aim_regs_props u_aim_regs_props (
  .sys_clk(sys_clk), .nrst(nrst), .host_wr(host_wr), .host_rd(host_rd),
  .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
  .evt(evt), .fe(fe), .irq_out(irq_out));

// ---- testbench/aim_regs_bench.sv ----
/*
  Self-checking bench for the interrupt and scan control registers.
  Assumes the checker is bound from its own file.
*/
module aim_regs_bench import aim_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [1:0] host_addr = 2'h0;
  logic [15:0] host_wdata = 16'h0000;
  logic [15:0] host_rdata;
  aim_evt_s evt = '0;
  aim_fe_s fe;
  logic irq_out;
  logic [15:0] rd_val;
  int error_cnt = 0;
  int tests_run = 0;
  always #5 sys_clk = ~sys_clk;
  aim_regs u_aim_regs (.sys_clk(sys_clk), .nrst(nrst), .host_wr(host_wr),
    .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .evt(evt), .fe(fe), .irq_out(irq_out));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    tick(1);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    tick(1);
    host_wr <= 1'b0;
  endtask
  // Answer sampled two cycles after the read edge, it stands until the next read
  task automatic rd(input logic [1:0] a);
    tick(1);
    host_rd <= 1'b1;
    host_addr <= a;
    tick(1);
    host_rd <= 1'b0;
    tick(2);
    #1 rd_val = host_rdata;
  endtask
  // Source event k, then flush the ADC level flags
  task automatic fire(input int k);
    tick(1);
    case (k)
      0: evt.ext_irq <= 1'b1;
      1: evt.conv_done <= 1'b1;
      2: evt.adc_level <= 9'h100;
      default: evt.adc_level <= 9'h001;
    endcase
    tick(1);
    evt <= 18'h0_0200;
    tick(1);
    evt <= '0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    wr(2'h1, 16'hffff);
    wr(2'h3, 16'hffff);
    for (int a = 0; a < 4; a++)
    begin
      rd(2'(a));
      chk(rd_val, 16'h0000);
    end
    chk({6'h00, fe}, 16'h0000);
    $display("t_reset done");
  endtask
  task automatic t_src();
    for (int s = 0; s < 4; s++)
    begin
      wr(2'h0, 16'h0084 | 16'(s));
      fire((s + 1) % 4);
      rd(2'h0);
      chk({15'h0000, rd_val[7]}, 16'h0000);
      fire(s);
      rd(2'h0);
      chk({15'h0000, rd_val[7]}, 16'h0001);
    end
    wr(2'h0, 16'h0083);
    fire(3);
    rd(2'h0);
    chk({15'h0000, rd_val[7]}, 16'h0000);
    $display("t_src done");
  endtask
  task automatic t_flags();
    wr(2'h0, 16'h1018);
    tick(1);
    evt <= 18'h2_fd00;
    tick(1);
    evt <= 18'h0_4100;
    rd(2'h0);
    chk(rd_val, 16'h7f60);
    chk({15'h0000, irq_out}, 16'h0001);
    wr(2'h0, 16'h1018);
    rd(2'h0);
    chk(rd_val, 16'h7f60);
    tick(1);
    evt <= 18'h0_0100;
    rd(2'h0);
    chk(rd_val, 16'h7d60);
    tick(1);
    evt <= 18'h0_0200;
    tick(1);
    evt <= '0;
    wr(2'h0, 16'h6060);
    rd(2'h0);
    chk(rd_val, 16'h0100);
    chk({15'h0000, irq_out}, 16'h0000);
    wr(2'h0, 16'h0080);
    rd(2'h0);
    chk(rd_val, 16'h0000);
    tick(1);
    evt <= 18'h0_38ff;
    tick(1);
    evt <= 18'h0_00ff;
    rd(2'h0);
    chk(rd_val, 16'h1800);
    tick(1);
    evt <= 18'h0_0200;
    tick(1);
    evt <= '0;
    rd(2'h0);
    chk(rd_val, 16'h0000);
    $display("t_flags done");
  endtask
  task automatic t_scan();
    logic [1:0] p;
    logic [15:0] w;
    for (int i = 0; i < 4; i++)
    begin
      p = 2'(i);
      w = {2'b11, p, p[0], p[1], p, 2'b00, p, 2'b00, p};
      wr(2'h2, w);
      rd(2'h2);
      chk(rd_val, w & 16'h3fff);
      chk({6'h00, fe}, {8'h00, p, p, p[1], p[0], p});
    end
    wr(2'h2, 16'h0042);
    tick(2);
    #1 chk({12'h000, fe.channel}, 16'h0002);
    for (int n = 0; n < 3; n++)
    begin
      tick(1);
      evt.conv_done <= 1'b1;
      tick(1);
      evt.conv_done <= 1'b0;
      tick(2);
      #1 chk({12'h000, fe.channel}, 16'(n == 2 ? 2 : 3 + n));
    end
    $display("t_scan done");
  endtask
  // ----------------------------------------------------------------
  // Run and verdict
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    tick(2);
    nrst <= 1'b1;
    t_reset();
    t_src();
    t_flags();
    t_scan();
    give_verdict();
  end
  // Whole run needs about 180 cycles
  initial
  begin
    #100000;
    error_cnt++;
    give_verdict();
  end
endmodule // aim_regs_bench
